// [pmbpg_pkg.sv]
// Behaviour
// - Page values 0x00 to 0x03 steer every paged command to channel 0 to 3; other values except 0xFF are reserved.
// - With page 0xFF a write or send to a global-capable command reaches every channel whose global mask bit is set.
// - Only clear-faults, operation and on/off-config accept page 0xFF; the host uses a real page for all else.
// - Reading a paged command with page 0xFF gives arbitrary data and raises the communication fault flag.
// - Writing a command without global support with page 0xFF is dropped and raises the communication fault flag.
// - Exponent-mantissa linear values are mantissa b[10:0] times two to the exponent b[15:11], both signed.
// - Unsigned linear output-voltage values use all 16 bits as unsigned mantissa with a fixed exponent of -13.
// - The page-select byte is read/write, not paged, and resets to 0x00 with no nonvolatile restore.
// - The global channel mask byte is nonvolatile with default 0x0F and picks the channels of global writes.
// - Mask bits 3 to 0 enable one channel each, 0 ignores global accesses, and bits 7 to 4 read as zero.
package pmbpg_pkg;
    // Command codes of the registers held here
    localparam logic [7:0] CMD_PAGE_SELECT = 8'h00;
    localparam logic [7:0] CMD_PROTECT_LEVEL = 8'h10;
    localparam logic [7:0] CMD_ALT_HOST_COMMAND = 8'hc8;
    localparam logic [7:0] CMD_ALT_HOST0_DATA = 8'hc9;
    localparam logic [7:0] CMD_ALT_HOST1_DATA = 8'hca;
    localparam logic [7:0] CMD_GLOBAL_CHANNEL_MASK = 8'he4;
    localparam logic [7:0] CMD_BUS_ADDRESS_BASE = 8'he6;
    // Reset values
    localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
    localparam logic [7:0] PROTECT_LEVEL_RST = 8'h00;
    localparam logic [3:0] GLOBAL_MASK_RST = 4'hf;
    localparam logic [6:0] BUS_ADDRESS_BASE_RST = 7'h5c;
    localparam logic [15:0] ALT_HOST_RST = 16'h0000;
    // Page values
    localparam logic [7:0] PAGE_GLOBAL = 8'hff;
    localparam int NUM_CHAN = 4;
    localparam logic [7:0] PAGE_LAST = 8'h03;
    // Data returned for reads that have no defined answer
    localparam logic [15:0] ARBITRARY_DATA = 16'h0000;
    // Linear format field layout
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_EXP_W = 5;
    localparam int LIN_MANT_W = 11;
    localparam logic signed [4:0] LIN_UNSIGNED_EXP = -5'sd13;
endpackage

// [pmbpg_lin_if.sv]
`timescale 1ns/1ps
// Carries a data word to the linear decoder and back
interface pmbpg_lin_if;
    logic [15:0] word;
    logic unsigned_fmt;
    logic signed [16:0] mantissa;
    logic signed [4:0] exponent;
    modport dec (input word, input unsigned_fmt,
                 output mantissa, output exponent);
    modport user (output word, output unsigned_fmt,
                  input mantissa, input exponent);
endinterface

// [pmbpg_lin_decode.sv]
`timescale 1ns/1ps
// Splits a linear data word into mantissa and exponent
module pmbpg_lin_decode (
    // Word in, fields out
    pmbpg_lin_if.dec lin
);
    always_comb begin
        if (lin.unsigned_fmt) begin
            lin.mantissa = signed'({1'b0, lin.word});
            lin.exponent = pmbpg_pkg::LIN_UNSIGNED_EXP;
        end else begin
            lin.mantissa = 17'(signed'(
                lin.word[pmbpg_pkg::LIN_MANT_W-1:0]));
            lin.exponent = signed'(lin.word[pmbpg_pkg::LIN_EXP_LSB +:
                                            pmbpg_pkg::LIN_EXP_W]);
        end
    end
endmodule // pmbpg_lin_decode

// [pmbpg_page_bank.sv]
`timescale 1ns/1ps
// Page select, global mask and fault flag behind the command engine
module pmbpg_page_bank #(
    parameter logic [7:0] OPERATION_CODE = 8'h01,
    parameter logic [7:0] ON_OFF_CONFIG_CODE = 8'h02,
    parameter logic [7:0] CLEAR_FAULTS_CODE = 8'h03
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Command requests from the protocol engine
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_paged_in,
    input wire logic req_unsigned_fmt_in,
    input wire logic [7:0] req_code_in,
    input wire logic [15:0] req_wdata_in,
    // Answer to the protocol engine
    output logic rsp_valid_out,
    output logic [15:0] rsp_rdata_out,
    // Channel side
    input wire logic [63:0] chan_rdata_in,
    output logic [3:0] chan_wr_out,
    output logic [3:0] chan_rd_out,
    output logic [7:0] chan_code_out,
    output logic [15:0] chan_wdata_out,
    output logic signed [16:0] chan_mantissa_out,
    output logic signed [4:0] chan_exponent_out,
    // Non-paged commands held elsewhere
    input wire logic [15:0] common_rdata_in,
    output logic common_wr_out,
    output logic common_rd_out,
    // Nonvolatile restore
    input wire logic nvm_load_in,
    input wire logic [3:0] nvm_global_mask_in,
    input wire logic [7:0] nvm_protect_level_in,
    input wire logic [6:0] nvm_bus_address_base_in,
    // State seen by the rest of the device
    output logic [7:0] page_select_out,
    output logic [3:0] global_channel_mask_out,
    output logic [7:0] protect_level_out,
    output logic [6:0] bus_address_base_out,
    output logic communication_fault_out
);
    // Register state
    logic [7:0] page_select_reg, page_select_next;
    logic [3:0] global_mask_reg, global_mask_next;
    logic [7:0] protect_level_reg, protect_level_next;
    logic [6:0] base_reg, base_next;
    logic [15:0] alt_cmd_reg, alt_cmd_next;
    logic [15:0] alt0_reg, alt0_next;
    logic [15:0] alt1_reg, alt1_next;
    logic fault_reg, fault_next;
    // Request answer state
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_rdata_reg, rsp_rdata_next;
    logic [3:0] chan_wr_reg, chan_wr_next;
    logic [3:0] chan_rd_reg, chan_rd_next;
    logic [7:0] code_reg, code_next;
    logic [15:0] wdata_reg, wdata_next;
    logic signed [16:0] mant_reg, mant_next;
    logic signed [4:0] exp_reg, exp_next;
    logic common_wr_reg, common_wr_next;
    logic common_rd_reg, common_rd_next;
    // Decode helpers
    logic page_is_global;
    logic page_is_chan;
    logic fault_set;
    logic fault_clear;

    pmbpg_lin_if lin ();

    // Commands allowed to use the global page
    function automatic logic takes_global(input logic [7:0] code);
        return (code == CLEAR_FAULTS_CODE) || (code == OPERATION_CODE) ||
               (code == ON_OFF_CONFIG_CODE);
    endfunction

    // One strobe bit for the selected channel
    function automatic logic [3:0] chan_onehot(input logic [7:0] page);
        return 4'(4'h1 << page[1:0]);
    endfunction

    // Decoder of the request data word
    assign lin.word = req_wdata_in;
    assign lin.unsigned_fmt = req_unsigned_fmt_in;

    pmbpg_lin_decode u_lin_decode (
        .lin(lin)
    );

    // Page classification
    assign page_is_global = (page_select_reg == pmbpg_pkg::PAGE_GLOBAL);
    assign page_is_chan = (page_select_reg <= pmbpg_pkg::PAGE_LAST);

    // Next values of registers and the answer
    always_comb begin
        page_select_next = page_select_reg;
        global_mask_next = global_mask_reg;
        protect_level_next = protect_level_reg;
        base_next = base_reg;
        alt_cmd_next = alt_cmd_reg;
        alt0_next = alt0_reg;
        alt1_next = alt1_reg;
        rsp_valid_next = 1'b0;
        rsp_rdata_next = rsp_rdata_reg;
        chan_wr_next = 4'h0;
        chan_rd_next = 4'h0;
        code_next = code_reg;
        wdata_next = wdata_reg;
        mant_next = mant_reg;
        exp_next = exp_reg;
        common_wr_next = 1'b0;
        common_rd_next = 1'b0;
        fault_set = 1'b0;
        fault_clear = 1'b0;
        if (nvm_load_in) begin
            global_mask_next = nvm_global_mask_in;
            protect_level_next = nvm_protect_level_in;
            base_next = nvm_bus_address_base_in;
        end
        if (req_valid_in) begin
            rsp_valid_next = 1'b1;
            rsp_rdata_next = pmbpg_pkg::ARBITRARY_DATA;
            code_next = req_code_in;
            wdata_next = req_wdata_in;
            mant_next = lin.mantissa;
            exp_next = lin.exponent;
            if (req_paged_in) begin
                if (page_is_global) begin
                    if (req_write_in && takes_global(req_code_in)) begin
                        // a clear mask bit skips that channel
                        chan_wr_next = global_mask_reg;
                        fault_clear = (req_code_in == CLEAR_FAULTS_CODE);
                    end else begin
                        // global read or refused write answers junk, flags fault
                        fault_set = 1'b1;
                    end
                end else if (page_is_chan) begin
                    // route to the one selected channel
                    if (req_write_in) begin
                        chan_wr_next = chan_onehot(page_select_reg);
                        fault_clear = (req_code_in == CLEAR_FAULTS_CODE);
                    end else begin
                        chan_rd_next = chan_onehot(page_select_reg);
                        rsp_rdata_next =
                            chan_rdata_in[16*page_select_reg[1:0] +: 16];
                    end
                end else begin
                    // Reserved page: nothing reaches a channel
                    fault_set = 1'b1;
                end
            end else begin
                case (req_code_in)
                    pmbpg_pkg::CMD_PAGE_SELECT: begin
                        if (req_write_in) begin
                            page_select_next = req_wdata_in[7:0];
                        end
                        rsp_rdata_next = {8'h00, page_select_reg};
                    end
                    pmbpg_pkg::CMD_PROTECT_LEVEL: begin
                        if (req_write_in) begin
                            protect_level_next = req_wdata_in[7:0];
                        end
                        rsp_rdata_next = {8'h00, protect_level_reg};
                    end
                    pmbpg_pkg::CMD_GLOBAL_CHANNEL_MASK: begin
                        if (req_write_in) begin
                            global_mask_next = req_wdata_in[3:0];
                        end
                        rsp_rdata_next = {12'h000, global_mask_reg};
                    end
                    pmbpg_pkg::CMD_BUS_ADDRESS_BASE: begin
                        if (req_write_in) begin
                            base_next = req_wdata_in[6:0];
                        end
                        rsp_rdata_next = {9'h000, base_reg};
                    end
                    pmbpg_pkg::CMD_ALT_HOST_COMMAND: begin
                        if (req_write_in) begin
                            alt_cmd_next = req_wdata_in;
                        end
                        rsp_rdata_next = alt_cmd_reg;
                    end
                    pmbpg_pkg::CMD_ALT_HOST0_DATA: begin
                        if (req_write_in) begin
                            alt0_next = req_wdata_in;
                        end
                        rsp_rdata_next = alt0_reg;
                    end
                    pmbpg_pkg::CMD_ALT_HOST1_DATA: begin
                        if (req_write_in) begin
                            alt1_next = req_wdata_in;
                        end
                        rsp_rdata_next = alt1_reg;
                    end
                    default: begin
                        // Handled by the common register file
                        common_wr_next = req_write_in;
                        common_rd_next = ~req_write_in;
                        rsp_rdata_next = common_rdata_in;
                    end
                endcase
            end
        end
        // Set beats clear so a same-cycle fault survives
        fault_next = fault_set | (fault_reg & ~fault_clear);
    end

    // Register update
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            page_select_reg <= pmbpg_pkg::PAGE_SELECT_RST;
            global_mask_reg <= pmbpg_pkg::GLOBAL_MASK_RST;
            protect_level_reg <= pmbpg_pkg::PROTECT_LEVEL_RST;
            base_reg <= pmbpg_pkg::BUS_ADDRESS_BASE_RST;
            alt_cmd_reg <= pmbpg_pkg::ALT_HOST_RST;
            alt0_reg <= pmbpg_pkg::ALT_HOST_RST;
            alt1_reg <= pmbpg_pkg::ALT_HOST_RST;
            fault_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0000;
            chan_wr_reg <= 4'h0;
            chan_rd_reg <= 4'h0;
            code_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            mant_reg <= 17'sh0_0000;
            exp_reg <= 5'sh00;
            common_wr_reg <= 1'b0;
            common_rd_reg <= 1'b0;
        end else begin
            page_select_reg <= page_select_next;
            global_mask_reg <= global_mask_next;
            protect_level_reg <= protect_level_next;
            base_reg <= base_next;
            alt_cmd_reg <= alt_cmd_next;
            alt0_reg <= alt0_next;
            alt1_reg <= alt1_next;
            fault_reg <= fault_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            chan_wr_reg <= chan_wr_next;
            chan_rd_reg <= chan_rd_next;
            code_reg <= code_next;
            wdata_reg <= wdata_next;
            mant_reg <= mant_next;
            exp_reg <= exp_next;
            common_wr_reg <= common_wr_next;
            common_rd_reg <= common_rd_next;
        end
    end

    // Outputs straight from flops
    assign rsp_valid_out = rsp_valid_reg;
    assign rsp_rdata_out = rsp_rdata_reg;
    assign chan_wr_out = chan_wr_reg;
    assign chan_rd_out = chan_rd_reg;
    assign chan_code_out = code_reg;
    assign chan_wdata_out = wdata_reg;
    assign chan_mantissa_out = mant_reg;
    assign chan_exponent_out = exp_reg;
    assign common_wr_out = common_wr_reg;
    assign common_rd_out = common_rd_reg;
    assign page_select_out = page_select_reg;
    assign global_channel_mask_out = global_mask_reg;
    assign protect_level_out = protect_level_reg;
    assign bus_address_base_out = base_reg;
    assign communication_fault_out = fault_reg;
endmodule // pmbpg_page_bank

// [pmbpg_page_bank_properties.sv]
`timescale 1ns/1ps
// Watches the bank ports; each check ties an answer to its request
module pmbpg_chk (
    // Clock, reset and requests
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_paged_in,
    input wire logic req_unsigned_fmt_in,
    input wire logic [7:0] req_code_in,
    input wire logic [15:0] req_wdata_in,
    // Answers and state
    input wire logic rsp_valid_out,
    input wire logic [15:0] rsp_rdata_out,
    input wire logic [3:0] chan_wr_out,
    input wire logic [3:0] chan_rd_out,
    input wire logic signed [16:0] chan_mantissa_out,
    input wire logic signed [4:0] chan_exponent_out,
    input wire logic [7:0] page_select_out,
    input wire logic [3:0] global_channel_mask_out,
    input wire logic communication_fault_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Request decode shared by several checks
    logic gp;
    logic gok;
    logic signed [4:0] wexp;
    logic signed [16:0] wman;
    assign gp = req_valid_in && req_paged_in && page_select_out == 8'hff;
    assign gok = req_code_in inside {8'h01, 8'h02, 8'h03};
    assign wexp = req_wdata_in[15:11];
    assign wman = {{6{req_wdata_in[10]}}, req_wdata_in[10:0]};
    a_answer_pulse: assert property (
        req_valid_in |=> rsp_valid_out) else $error("no answer");
    a_no_stray: assert property (
        !req_valid_in |=> !rsp_valid_out) else $error("stray answer");
    a_page_store: assert property (
        req_valid_in && req_write_in && !req_paged_in && req_code_in == 8'h00
        |=> page_select_out == 8'($past(req_wdata_in)))
        else $error("page not stored");
    a_chan_route: assert property (
        req_valid_in && req_paged_in && page_select_out < 8'h04
        |=> (chan_wr_out | chan_rd_out) == (4'b0001 << $past(page_select_out)))
        else $error("wrong channel");
    a_global_write: assert property (
        gp && req_write_in && gok
        |=> chan_wr_out == $past(global_channel_mask_out))
        else $error("global write not masked");
    a_global_refuse: assert property (
        gp && req_write_in && !gok
        |=> chan_wr_out == 4'h0 && communication_fault_out)
        else $error("global write not refused");
    a_global_read: assert property (
        gp && !req_write_in |=> chan_rd_out == 4'h0 &&
        communication_fault_out && rsp_rdata_out == 16'h0000)
        else $error("global read not refused");
    a_fault_clear: assert property (
        gp && req_write_in && req_code_in == 8'h03
        |=> !communication_fault_out) else $error("fault not cleared");
    a_mask_read: assert property (
        req_valid_in && !req_write_in && !req_paged_in &&
        req_code_in == 8'he4
        |=> rsp_rdata_out == {12'h000, $past(global_channel_mask_out)})
        else $error("mask read wrong");
    a_lin_unsigned: assert property (
        req_valid_in && req_unsigned_fmt_in |=> chan_exponent_out == -5'sd13
        && chan_mantissa_out == $signed({1'b0, $past(req_wdata_in)}))
        else $error("unsigned decode wrong");
    a_lin_signed: assert property (
        req_valid_in && !req_unsigned_fmt_in |=> chan_exponent_out ==
        $past(wexp) && chan_mantissa_out == $past(wman))
        else $error("signed decode wrong");
    // Main scenarios reached
    c_global_write: cover property (gp && req_write_in && gok);
    c_global_read: cover property (gp && !req_write_in);
    c_reserved: cover property (req_valid_in && req_paged_in &&
        page_select_out inside {[8'h04:8'hfe]});
endmodule // pmbpg_chk
bind pmbpg_page_bank pmbpg_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_paged_in(req_paged_in), .req_unsigned_fmt_in(req_unsigned_fmt_in),
    .req_code_in(req_code_in), .req_wdata_in(req_wdata_in),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .chan_wr_out(chan_wr_out), .chan_rd_out(chan_rd_out),
    .chan_mantissa_out(chan_mantissa_out),
    .chan_exponent_out(chan_exponent_out),
    .page_select_out(page_select_out),
    .global_channel_mask_out(global_channel_mask_out),
    .communication_fault_out(communication_fault_out));

// [pmbpg_host_model.sv]
`timescale 1ns/1ps
// Host side: one command per call; released code, data and format lines are inverted, write and paged lines hold
module pmbpg_host_model (
    // Clock
    input wire logic clk_in,
    // Request lines
    output logic req_valid_out,
    output logic req_write_out,
    output logic req_paged_out,
    output logic req_unsigned_fmt_out,
    output logic [7:0] req_code_out,
    output logic [15:0] req_wdata_out
);
    // Idle at time zero
    initial begin
        req_valid_out = 1'b0;
        req_write_out = 1'b0;
        req_paged_out = 1'b0;
        req_unsigned_fmt_out = 1'b0;
        req_code_out = 8'h00;
        req_wdata_out = 16'h0000;
    end
    // caller picks page, word already encoded
    task automatic xfer(input logic w, p, u, input logic [7:0] c,
                        input logic [15:0] d);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_write_out <= w;
        req_paged_out <= p;
        req_unsigned_fmt_out <= u;
        req_code_out <= c;
        req_wdata_out <= d;
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        req_code_out <= ~c;
        req_wdata_out <= ~d;
        req_unsigned_fmt_out <= ~u;
    endtask
endmodule // pmbpg_host_model

// [pmbpg_page_bank_tb.sv]
`timescale 1ns/1ps
// Commands through the host model, compared with a small integer model
module pmbpg_page_bank_tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [63:0] chan_rdata = '0;
    logic [15:0] common_rdata = '0;
    logic rv, wr, pg, uf, rsp_valid, cwr, crd, fault;
    logic [7:0] code, page, prot, ccode;
    logic [15:0] wdata, cwdata, rsp_rdata;
    logic [3:0] chwr, chrd, mask;
    logic [6:0] base;
    logic signed [16:0] mant;
    logic signed [4:0] expo;
    int fails = 0;
    int check_count = 0;
    int page_m = 0;
    int mask_m = 15;
    int fault_m = 0;
    int store_m [256];
    logic nvm_load = 1'b0;
    logic [3:0] nvm_mask = '0;
    logic [7:0] nvm_prot = '0;
    logic [6:0] nvm_base = '0;
    logic [7:0] sto [5] = '{8'h10, 8'hc8, 8'hc9, 8'hca, 8'he6};
    logic [31:0] seed = 32'd88535;
    logic [7:0] tab [8] = '{8'h00, 8'he4, 8'h20, 8'h01, 8'h02, 8'h03,
                            8'h21, 8'h8b};
    always #25 clk_in = ~clk_in;
    // Nonvolatile restore driven by the bench as a stand-in store
    pmbpg_page_bank u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .req_valid_in(rv), .req_write_in(wr), .req_paged_in(pg),
        .req_unsigned_fmt_in(uf), .req_code_in(code), .req_wdata_in(wdata),
        .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata),
        .chan_rdata_in(chan_rdata), .chan_wr_out(chwr), .chan_rd_out(chrd),
        .chan_code_out(ccode), .chan_wdata_out(cwdata),
        .chan_mantissa_out(mant), .chan_exponent_out(expo),
        .common_rdata_in(common_rdata), .common_wr_out(cwr),
        .common_rd_out(crd), .nvm_load_in(nvm_load),
        .nvm_global_mask_in(nvm_mask), .nvm_protect_level_in(nvm_prot),
        .nvm_bus_address_base_in(nvm_base),
        .page_select_out(page), .global_channel_mask_out(mask),
        .protect_level_out(prot), .bus_address_base_out(base),
        .communication_fault_out(fault));
    pmbpg_host_model u_host (.clk_in(clk_in), .req_valid_out(rv),
        .req_write_out(wr), .req_paged_out(pg), .req_unsigned_fmt_out(uf),
        .req_code_out(code), .req_wdata_out(wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'ha300_0000 : 32'h0000_0000);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One command, then the model predicts and every result but the read data of a write is compared
    task automatic op(input logic w, p, u, input logic [7:0] c,
                      input logic [15:0] d);
        logic [3:0] ewr;
        logic [3:0] erd;
        logic [15:0] ed;
        logic ok;
        logic signed [16:0] em;
        logic signed [4:0] ee;
        seed = lfsr(seed);
        @(posedge clk_in);
        chan_rdata <= {seed, ~seed};
        common_rdata <= seed[15:0] ^ 16'h5a5a;
        u_host.xfer(w, p, u, c, d);
        #1;
        ewr = 4'h0;
        erd = 4'h0;
        ed = 16'h0000;
        ok = 1'b1;
        if (p && page_m < 4) begin
            if (w) ewr[page_m] = 1'b1;
            else erd[page_m] = 1'b1;
            ed = chan_rdata[16*page_m +: 16];
        end else if (p) begin
            ok = page_m == 255 && w && c >= 1 && c <= 3;
            ewr = ok ? 4'(mask_m) : 4'h0;
        end else if (w && c == 8'h00) page_m = int'(d[7:0]);
        else if (w && c == 8'he4) mask_m = int'(d[3:0]);
        else if (c == 8'h00) ed = 16'(page_m);
        else if (c == 8'he4) ed = 16'(mask_m);
        else if (c inside {8'h10, 8'hc8, 8'hc9, 8'hca, 8'he6}) begin
            // Plain storage, narrowed to the width each register keeps
            if (w) store_m[c] = int'(d) &
                (c == 8'h10 ? 'hff : (c == 8'he6 ? 'h7f : 'hffff));
            ed = 16'(store_m[c]);
        end else ed = common_rdata;
        if (!ok) fault_m = 1;
        else if (w && c == 8'h03) fault_m = 0;
        em = u ? {1'b0, d} : {{6{d[10]}}, d[10:0]};
        ee = u ? -5'sd13 : d[15:11];
        check(32'(rsp_valid), 32'd1);
        check(32'(chwr), 32'(ewr));
        check(32'(chrd), 32'(erd));
        check({cwr, crd}, {!p && w && c == 8'h20, !p && !w && c == 8'h20});
        if (!w) check(32'(rsp_rdata), 32'(ed));
        check(32'(fault), 32'(fault_m));
        check({page, 4'h0, mask}, {8'(page_m), 8'(mask_m)});
        check({prot, 1'b0, base}, {8'(store_m[16]), 8'(store_m[230])});
        check({ccode, cwdata}, {c, d});
        check(32'(mant), 32'(em));
        check(32'(expo), 32'(ee));
    endtask
    // Main sequence
    initial begin
        store_m[8'he6] = 'h5c;
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        check({page, prot, 4'h0, mask, fault, base},
              {16'h0000, 8'h0f, 1'b0, 7'h5c});
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 1'b0, 8'h00, 16'(i));
            op(1'b0, 1'b1, 1'b0, 8'h8b, 16'h0000);
            op(1'b1, 1'b1, 1'b1, 8'h21, seed[15:0]);
        end
        op(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        $display("Test pages done");
        // Upper mask bits written high must read back as zero
        op(1'b1, 1'b0, 1'b0, 8'he4, 16'h00fa);
        op(1'b0, 1'b0, 1'b0, 8'he4, 16'h0000);
        op(1'b1, 1'b0, 1'b0, 8'h00, 16'h0007);
        op(1'b0, 1'b1, 1'b0, 8'h8b, 16'h0000);
        op(1'b1, 1'b0, 1'b0, 8'h00, 16'h00ff);
        for (int c = 1; c < 4; c++) op(1'b1, 1'b1, 1'b0, 8'(c), 16'h0000);
        op(1'b1, 1'b1, 1'b0, 8'h21, 16'h1234);
        op(1'b0, 1'b1, 1'b0, 8'h21, 16'h0000);
        $display("Test global done");
        // Plain storage codes: write random, read back
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            op(1'b1, 1'b0, 1'b0, sto[k], seed[31:16]);
            op(1'b0, 1'b0, 1'b0, sto[k], 16'h0000);
        end
        seed = lfsr(seed);
        @(posedge clk_in);
        nvm_load <= 1'b1;
        {nvm_prot, nvm_base, nvm_mask} <= seed[18:0];
        @(posedge clk_in);
        nvm_load <= 1'b0;
        mask_m = int'(seed[3:0]);
        store_m[230] = int'(seed[10:4]);
        store_m[16] = int'(seed[18:11]);
        #1;
        check({prot, 1'b0, base, 4'h0, mask},
              {seed[18:11], 1'b0, seed[10:4], 4'h0, seed[3:0]});
        op(1'b0, 1'b0, 1'b0, 8'he4, 16'h0000);
        $display("Test storage done");
        repeat (80) begin
            seed = lfsr(seed);
            op(seed[0], seed[5:3] > 3'd2, seed[1], tab[seed[5:3]],
               seed[5:3] != 3'd0 ? seed[31:16] :
               (seed[6] ? 16'h00ff : 16'(seed[8:7])));
        end
        $display("Test random done");
        results();
    end
    // Run needs under 500 cycles; a hang ends here
    initial begin
        repeat (5000) @(posedge clk_in);
        fails++;
        results();
    end
endmodule // pmbpg_page_bank_tb
